// File: rtl/tbid_decode.sv
// Module: twelve bit instruction decode and execute
// Function
// - Byte format: d at bit 5 picks W (0) or file (1); f is bits 4..0.
// - Bit format: bit number in bits 7..5, file index in bits 4..0.
// - Literal format: bits 7..0 are the 8-bit immediate.
// - Jump format: bits 8..0 are a 9-bit target, opcode in bits 11..9.
// - Nibble exchange writes swapped file value to W or file, no flags.
// - Direction load copies W into direction register when f is 6.
// - XOR literal replaces W with W xor k, changes only zero flag.
// - One instruction cycle is four clocks; jump takes two cycles.
`timescale 1ns/10ps
module tbid_decode
  import tbid_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [TBID_IW-1:0]   instr,
  input  wire logic [TBID_DW-1:0]   file_rdata,
  output logic      [TBID_FW-1:0]   file_addr,
  output logic      [TBID_BW-1:0]   bit_sel,
  output logic      [TBID_DW-1:0]   file_wdata,
  output logic                      file_we,
  output logic      [TBID_DW-1:0]   w_reg,
  output logic                      zero_flag,
  output logic      [TBID_DW-1:0]   pin_dir,
  output logic                      jump_op,
  output logic      [TBID_K9W-1:0]  jump_target,
  output logic                      fetch,
  output logic                      flush
);

  // ==========================================================
  // Field decode
  logic [TBID_DW-1:0] imm8;
  logic               dsel;
  logic               nibble_exchange_op;
  logic               direction_load_op;
  logic               xor_literal_op;
  logic               is_jump;
  logic [TBID_DW-1:0] swapped;
  logic [TBID_DW-1:0] xored;

  always_comb begin
    dsel               = instr[TBID_D_BIT];
    imm8               = instr[TBID_DW-1:0];
    nibble_exchange_op = (instr[11:6] == TBID_OP_SWAP);
    direction_load_op  = (instr[11:3] == TBID_OP_DIRECTION_LOAD_OP) &&
                         (instr[2:0] == TBID_DIRECTION_LOAD_OP_F);
    xor_literal_op     = (instr[11:8] == TBID_OP_XORL);
    is_jump            = (instr[11:TBID_OP_LSB_J] == TBID_OP_JUMP);
    swapped            = {file_rdata[3:0], file_rdata[7:4]};
    xored              = w_reg ^ imm8;
    file_addr          = instr[TBID_F_LSB +: TBID_FW];
    bit_sel            = instr[TBID_B_LSB +: TBID_BW];
    jump_target        = instr[TBID_K9W-1:0];
  end

  // ==========================================================
  // Instruction cycle sequencing
  tbid_phase_e phase;
  tbid_phase_e next_phase;
  logic        skip;
  logic        next_skip;

  always_comb begin
    next_phase = phase;
    next_skip  = skip;
    unique case (phase)
      TBID_Q1: next_phase = TBID_Q2;
      TBID_Q2: next_phase = TBID_Q3;
      TBID_Q3: next_phase = TBID_Q4;
      TBID_Q4: begin
        next_phase = TBID_Q1;
        next_skip  = !skip && is_jump;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase <= TBID_Q1;
      skip  <= 1'b0;
    end else begin
      phase <= next_phase;
      skip  <= next_skip;
    end
  end

  logic exec;
  always_comb begin
    exec    = (phase == TBID_Q4) && !skip;
    fetch   = (phase == TBID_Q4);
    flush   = skip;
    jump_op = exec && is_jump;
  end

  // ==========================================================
  // Execute: accumulator, flag, direction and file writes
  logic [TBID_DW-1:0] next_w;
  logic               next_z;
  logic [TBID_DW-1:0] next_dir;
  logic [TBID_DW-1:0] next_fwd;
  logic               next_fwe;

  always_comb begin
    next_w   = w_reg;
    next_z   = zero_flag;
    next_dir = pin_dir;
    next_fwd = file_wdata;
    next_fwe = 1'b0;
    if (exec) begin
      if (nibble_exchange_op) begin
        if (dsel) begin
          next_fwd = swapped;
          next_fwe = 1'b1;
        end else begin
          next_w   = swapped;
        end
      end else if (direction_load_op) begin
        next_dir = w_reg;
      end else if (xor_literal_op) begin
        next_w = xored;
        next_z = (xored == '0);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      w_reg      <= TBID_W_RST;
      zero_flag  <= 1'b0;
      pin_dir    <= TBID_DIR_RST;
      file_wdata <= '0;
      file_we    <= 1'b0;
    end else begin
      w_reg      <= next_w;
      zero_flag  <= next_z;
      pin_dir    <= next_dir;
      file_wdata <= next_fwd;
      file_we    <= next_fwe;
    end
  end

endmodule : tbid_decode

// File: rtl/tbid_pkg.sv
// Package: constants for the twelve bit instruction decoder
package tbid_pkg;

  // ==========================================================
  // Instruction word fields
  localparam int TBID_IW       = 12;
  localparam int TBID_DW       = 8;
  localparam int TBID_FW       = 5;
  localparam int TBID_BW       = 3;
  localparam int TBID_D_BIT    = 5;
  localparam int TBID_F_LSB    = 0;
  localparam int TBID_B_LSB    = 5;
  localparam int TBID_K9W      = 9;
  localparam int TBID_OP_LSB_J = 9;

  // ==========================================================
  // Encodings
  localparam logic [5:0]  TBID_OP_SWAP  = 6'h0E;
  localparam logic [8:0]  TBID_OP_DIRECTION_LOAD_OP  = 9'h000;
  localparam logic [2:0]  TBID_DIRECTION_LOAD_OP_F   = 3'h6;
  localparam logic [3:0]  TBID_OP_XORL  = 4'hF;
  localparam logic [2:0]  TBID_OP_JUMP  = 3'h5;

  // ==========================================================
  // Timing and reset values
  localparam int          TBID_QPHASES  = 4;
  localparam logic [7:0]  TBID_W_RST    = 8'h00;
  localparam logic [7:0]  TBID_DIR_RST  = 8'hFF;

  typedef enum logic [1:0] {
    TBID_Q1, TBID_Q2, TBID_Q3, TBID_Q4
  } tbid_phase_e;

endpackage : tbid_pkg

// File: verif/tbid_decode_props.sv
// Checker: decoder port properties
`timescale 1ns/10ps
module tbid_decode_props
  import tbid_pkg::*;
(
  input wire logic clk, nrst, file_we, zero_flag, jump_op, fetch, flush,
  input wire logic [11:0] instr,
  input wire logic [7:0]  file_rdata, file_wdata, w_reg, pin_dir,
  input wire logic [2:0]  bit_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire logic ex = fetch && !flush, xo = ex && instr[11:8] == 4'hF;
  chk_bit_field: assert property
    (bit_sel == instr[7:5]) else $error("bit_sel");
  chk_fetch_period: assert property
    (fetch |=> !fetch [*3] ##1 fetch) else $error("fetch");
  chk_xor_acc: assert property
    (xo |=> w_reg == ($past(w_reg) ^ $past(instr[7:0]))) else $error("xor");
  chk_zero_value: assert property
    (xo |=> zero_flag == (w_reg == 8'h00)) else $error("zero");
  chk_zero_hold: assert property
    (!xo |=> $stable(zero_flag)) else $error("flag");
  chk_swap_file: assert property
    (ex && instr[11:5] == 7'h1D |=> file_we &&
     file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap");
  chk_dir_load: assert property
    (ex && instr == 12'h006 |=> pin_dir == $past(w_reg)) else $error("dir");
  chk_jump_dead: assert property
    (ex && instr[11:9] == 3'h5 |-> jump_op ##1 flush) else $error("jump");
endmodule : tbid_decode_props
bind tbid_decode tbid_decode_props i_tbid_decode_props (.*);

// File: verif/tb_tbid_decode.sv
// Testbench: random instruction stream against a reference model
`timescale 1ns/10ps
module tb_tbid_decode;
  logic clk = 0, nrst = 0, v, q = 0, z = 0;
  logic [11:0] instr = 0;
  logic [7:0]  file_rdata = 0, w = 0, d = 8'hFF, r, fw = 0;
  int          k, error_cnt = 0, n_tests = 0;
  wire logic [7:0] w_reg, pin_dir, file_wdata;
  wire logic       zero_flag, file_we, jump_op, fetch, flush;
  wire logic [4:0] file_addr;
  wire logic [8:0] jump_target;
  always #12.5 clk = ~clk;
  tbid_decode i_tbid_decode (.bit_sel(), .*);
  task automatic cmp(string s, logic [11:0] e, logic [11:0] g);
    n_tests++;
    error_cnt += int'(g !== e);
    if (g !== e) $display("ERROR %s exp %h got %h", s, e, g);
  endtask : cmp
  task automatic end_of_test;
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic step(logic [11:0] i);
    instr = i;
    file_rdata = r;
    for (k = 0; k < 8 && fetch !== 1'b1; k++) @(posedge clk) #2;
    error_cnt += int'(k == 8);
    if (k == 8) end_of_test();
    v = !q;
    q = v && i[11:9] == 3'h5;
    cmp("jump_op", q, jump_op);
    cmp("file_addr", i[4:0], file_addr);
    cmp("jump_target", i[8:0], jump_target);
    if (v && i[11:5] == 7'h1D) fw = {r[3:0], r[7:4]};
    if (v && i[11:8] == 4'hF) {z, w} = {(w ^ i[7:0]) == 0, w ^ i[7:0]};
    if (v && i[11:5] == 7'h1C) w = {r[3:0], r[7:4]};
    if (v && i == 12'h006) d = w;
    @(posedge clk) #2;
    cmp("w_reg", w, w_reg);
    cmp("zero_flag", z, zero_flag);
    cmp("pin_dir", d, pin_dir);
    cmp("file_we", v && i[11:5] == 7'h1D, file_we);
    cmp("file_wdata", fw, file_wdata);
    cmp("flush", q, flush);
  endtask : step
  initial begin
    r = 8'($urandom(23));
    repeat (5) @(posedge clk);
    #2 nrst = 1;
    repeat (400) begin
      r = 8'($urandom);
      case ($urandom % 6)
        0: step({4'hF, r});
        1: step({4'hF, w});
        2: step({6'h0E, r[5:0]});
        3: step(12'h006);
        4: step({3'h5, r, 1'b0});
        default: step(12'($urandom));
      endcase
    end
    end_of_test();
  end
endmodule : tb_tbid_decode
